// *** verilog/ebw_pkg.sv ***
// Package of register offsets, fields and reset values for the external bus wait and bank control
package ebw_pkg;
  localparam logic [15:0] EBW_BANK_SWITCH_CONTROL_ADDR = 16'h0029;
  localparam logic [15:0] EBW_WAIT_STATE_BASE_ADDR = 16'h0028;
  localparam logic [15:0] EBW_WAIT_STATE_CONTROL_ADDR = 16'h002B;
  localparam logic [15:0] EBW_BASE_RESET = 16'h7FFF;
  localparam logic [15:0] EBW_BSC_RESET = 16'hF800;
  localparam logic [15:0] EBW_BSC_WMASK = 16'hF807;
  localparam logic [15:0] EBW_WSC_WMASK = 16'h0001;
  localparam int EBW_KEEP_HOST = 2;
  localparam int EBW_KEEP_EXT = 1;
  localparam int EBW_OFF_BIT = 0;
  localparam int EBW_GAP_BIT = 11;
  localparam logic [3:0] EBW_ZERO_WAIT = 4'h0;
  localparam logic [3:0] EBW_ONE_WAIT = 4'h1;
  typedef enum logic [1:0] {
    EBW_SPACE_PROG = 2'b00,
    EBW_SPACE_DATA = 2'b01,
    EBW_SPACE_IO = 2'b10
  } ebw_space_t;
  typedef enum logic [1:0] {
    EBW_IDLE = 2'b00,
    EBW_GAP = 2'b01,
    EBW_WAIT = 2'b10,
    EBW_DONE = 2'b11
  } ebw_state_t;
endpackage

// *** verilog/ebw_bus_ctrl.sv ***
// External bus wait-state, bank-switch and bus-off control
`timescale 1ns/100ps
`default_nettype none
// What this block does
// R01: Multiplier bit zero keeps base waits; one doubles them, fourteen at most.
// R02: Reserved bits of both control registers reset to zero and ignore writes.
// R03: One extra cycle when consecutive accesses cross a bank within program space or within data space.
// R04: Bank-switch cycle also inserted when moving from data into program space.
// R05: Four-bit compare field masks top four address bits; resets to ones.
// R06: All ones compares bits 12 to 15, 4K bank; 4K to 64K supported.
// R07: Gap bit set inserts one cycle between program and data reads, either order.
// R08: Host keeper bit enables holding the 8-bit host data bus when undriven.
// R09: External keeper bit enables holding the 16-bit data bus when undriven.
// R10: Bus-off bit finishes current cycle then makes address, data, control inactive.
// R11: While bus off, mode bits data-ROM, micro mode, overlay, hold stay blocked.
// R12: I/O space of 64K ports reached only by port read and write instructions.
// R13: I/O strobe asserted during every read or write to I/O space.
// R14: Five 3-bit base fields set waits for five address ranges.
// R15: After reset every external access gets seven wait states.
// R16: Devices needing over fourteen waits hold ready low to stretch access.
// R17: Access ends only after effective waits elapse and ready is sampled high.
module ebw_bus_ctrl
  import ebw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic mmr_wr,
  input wire logic mmr_rd,
  input wire logic [15:0] mmr_addr,
  input wire logic [15:0] mmr_wdata,
  output logic [15:0] mmr_rdata,
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic [1:0] acc_space,
  input wire logic [15:0] acc_addr,
  input wire logic [15:0] acc_wdata,
  input wire logic ready,
  output logic acc_done,
  output logic [15:0] ext_addr,
  output logic [15:0] ext_dout,
  output logic ext_dout_en_n,
  output logic ext_strobe,
  output logic ext_rw,
  output logic io_space_strobe,
  output logic ext_bus_keeper,
  output logic host_bus_keeper,
  output logic mode_bits_locked
);
  logic [15:0] base_q;
  logic [15:0] bsc_q;
  logic [15:0] wsc_q;
  ebw_state_t state_q;
  ebw_state_t state_d;
  logic [3:0] wait_q;
  logic [3:0] wait_d;
  logic [3:0] last_bank_q;
  logic [1:0] last_space_q;
  logic last_read_q;
  logic have_last_q;
  logic off_q;
  logic [1:0] cur_space_q;
  logic [15:0] cur_addr_q;
  logic cur_write_q;
  logic [15:0] cur_wdata_q;

  wire sel_base = (mmr_addr == EBW_WAIT_STATE_BASE_ADDR);
  wire sel_bsc = (mmr_addr == EBW_BANK_SWITCH_CONTROL_ADDR);
  wire sel_wsc = (mmr_addr == EBW_WAIT_STATE_CONTROL_ADDR);
  wire idle = (state_q == EBW_IDLE);
  wire start = idle && acc_req && !off_q;
  // R14 base field per range
  wire [2:0] base_sel = (acc_space == EBW_SPACE_IO) ? base_q[14:12] :
    (acc_space == EBW_SPACE_DATA) ? (acc_addr[15] ? base_q[11:9] : base_q[8:6]) :
    (base_q[15] ? base_q[2:0] : (acc_addr[15] ? base_q[5:3] : base_q[2:0]));
  // R01 multiplier doubles base count
  wire [3:0] eff_wait = wsc_q[0] ? {base_sel, 1'b0} : {1'b0, base_sel};
  // R05 compare field masks address top bits
  wire [3:0] bank_mask = bsc_q[15:12];
  // R06 bank change within the masked bits
  wire bank_diff = ((acc_addr[15:12] ^ last_bank_q) & bank_mask) != 4'h0;
  wire acc_read = !acc_write;
  // R03 crossing inside the same space
  wire cross_same = (acc_space == last_space_q) && acc_space != EBW_SPACE_IO && bank_diff;
  // R04 data space into program space
  wire cross_dp = (last_space_q == EBW_SPACE_DATA) && (acc_space == EBW_SPACE_PROG);
  // R07 program and data reads back to back
  wire rd_switch = bsc_q[EBW_GAP_BIT] && acc_read && last_read_q &&
    (((acc_space == EBW_SPACE_PROG) && (last_space_q == EBW_SPACE_DATA)) ||
     ((acc_space == EBW_SPACE_DATA) && (last_space_q == EBW_SPACE_PROG)));
  wire need_gap = have_last_q && (cross_same || cross_dp || rd_switch);
  wire wait_over = (wait_q == EBW_ZERO_WAIT);

  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    case (state_q)
      EBW_IDLE: begin
        if (start) begin
          wait_d = eff_wait;
          state_d = need_gap ? EBW_GAP : EBW_WAIT;
        end
      end
      EBW_GAP: state_d = EBW_WAIT;
      EBW_WAIT: begin
        if (!wait_over) begin
          wait_d = wait_q - EBW_ONE_WAIT;
        end else if (ready) begin
          // R17 end after count and ready high
          state_d = EBW_DONE;
        end
      end
      EBW_DONE: state_d = EBW_IDLE;
      default: state_d = EBW_IDLE;
    endcase
  end

  // R02 reserved bits masked on write
  wire [15:0] bsc_wr = (bsc_q & ~EBW_BSC_WMASK) | (mmr_wdata & EBW_BSC_WMASK);
  wire [15:0] wsc_wr = (wsc_q & ~EBW_WSC_WMASK) | (mmr_wdata & EBW_WSC_WMASK);
  wire [15:0] rdata_d = sel_base ? base_q : sel_bsc ? bsc_q : sel_wsc ? wsc_q : 16'h0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // R15 seven waits everywhere after reset
      base_q <= EBW_BASE_RESET;
      bsc_q <= EBW_BSC_RESET;
      wsc_q <= 16'h0000;
      mmr_rdata <= 16'h0000;
    end else if (clk_en) begin
      if (mmr_wr && sel_base) base_q <= mmr_wdata;
      if (mmr_wr && sel_bsc) bsc_q <= bsc_wr;
      if (mmr_wr && sel_wsc) wsc_q <= wsc_wr;
      if (mmr_rd) mmr_rdata <= rdata_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= EBW_IDLE;
      wait_q <= EBW_ZERO_WAIT;
      last_bank_q <= 4'h0;
      last_space_q <= EBW_SPACE_PROG;
      last_read_q <= 1'b0;
      have_last_q <= 1'b0;
      cur_space_q <= EBW_SPACE_PROG;
      cur_addr_q <= 16'h0000;
      cur_write_q <= 1'b0;
      cur_wdata_q <= 16'h0000;
    end else if (clk_en) begin
      state_q <= state_d;
      wait_q <= wait_d;
      if (start) begin
        last_bank_q <= acc_addr[15:12];
        last_space_q <= acc_space;
        last_read_q <= acc_read;
        have_last_q <= 1'b1;
        cur_space_q <= acc_space;
        cur_addr_q <= acc_addr;
        cur_write_q <= acc_write;
        cur_wdata_q <= acc_wdata;
      end
    end
  end

  wire busy_d = (state_d == EBW_GAP) || (state_d == EBW_WAIT);
  wire drive_d = busy_d && (state_d == EBW_WAIT);
  wire acc_is_wr = start ? acc_write : cur_write_q;
  // Write data kept aside, a gap cycle would otherwise lose it
  wire [15:0] wdata_sel = start ? acc_wdata : cur_wdata_q;
  // R10 latch bus off between cycles
  // A request taken on this edge still runs to its end first
  wire off_d = ((idle && !start) || state_q == EBW_DONE) ? bsc_q[EBW_OFF_BIT] : off_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      off_q <= 1'b0;
      acc_done <= 1'b0;
      ext_addr <= 16'h0000;
      ext_dout <= 16'h0000;
      ext_dout_en_n <= 1'b1;
      ext_strobe <= 1'b0;
      ext_rw <= 1'b1;
      io_space_strobe <= 1'b0;
      ext_bus_keeper <= 1'b0;
      host_bus_keeper <= 1'b0;
      mode_bits_locked <= 1'b0;
    end else if (clk_en) begin
      off_q <= off_d;
      acc_done <= (state_d == EBW_DONE);
      // R12 full 16-bit port address
      ext_addr <= busy_d ? (start ? acc_addr : cur_addr_q) : 16'h0000;
      ext_dout <= (drive_d && acc_is_wr) ? wdata_sel : 16'h0000;
      ext_dout_en_n <= !(drive_d && acc_is_wr);
      ext_strobe <= drive_d;
      ext_rw <= !(drive_d && acc_is_wr);
      // R13 I/O strobe for port space cycles
      io_space_strobe <= drive_d && ((start ? acc_space : cur_space_q) == EBW_SPACE_IO);
      // R09 external data keeper
      ext_bus_keeper <= bsc_q[EBW_KEEP_EXT];
      // R08 host data keeper
      host_bus_keeper <= bsc_q[EBW_KEEP_HOST];
      // R11 lock mode bits while off
      mode_bits_locked <= off_d;
    end
  end

  a_double_wait: assert property (@(posedge clk) disable iff (rst) // R01
    (clk_en && start && wsc_q[0]) |=> wait_q == {$past(base_sel), 1'b0})
    else $error("wait not doubled");
  a_reserved_zero: assert property (@(posedge clk) disable iff (rst) // R02
    (bsc_q[10:3] == 8'h00) && (wsc_q[15:1] == 15'h0000))
    else $error("reserved bit set");
  a_bank_gap: assert property (@(posedge clk) disable iff (rst) // R03
    (clk_en && start && have_last_q && cross_same) |=> state_q == EBW_GAP)
    else $error("bank gap missing");
  a_read_gap: assert property (@(posedge clk) disable iff (rst) // R07
    (clk_en && start && have_last_q && rd_switch) |=> state_q == EBW_GAP)
    else $error("read gap missing");
  a_off_idle: assert property (@(posedge clk) disable iff (rst) // R10
    off_q |-> !ext_strobe && ext_addr == 16'h0000)
    else $error("bus active while off");
  a_io_strobe: assert property (@(posedge clk) disable iff (rst) // R13
    io_space_strobe |-> ext_strobe && cur_space_q == EBW_SPACE_IO)
    else $error("io strobe wrong");
  a_ready_end: assert property (@(posedge clk) disable iff (rst) // R17
    (clk_en && state_q == EBW_WAIT && !ready) |=> state_q != EBW_DONE)
    else $error("ended without ready");
  a_keeper_follow: assert property (@(posedge clk) disable iff (rst) // R09
    clk_en |=> ext_bus_keeper == $past(bsc_q[EBW_KEEP_EXT]))
    else $error("keeper mismatch");
  c_gap_seen: cover property (@(posedge clk) state_q == EBW_GAP);
  c_done_seen: cover property (@(posedge clk) acc_done);
  c_io_seen: cover property (@(posedge clk) io_space_strobe);
endmodule
`default_nettype wire

// *** test/ebw_ext_mem.sv ***
// Model of the external memory side, answering each access with ready
`timescale 1ns/100ps
`default_nettype none
module ebw_ext_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic ext_strobe,
  input wire logic [3:0] stall,
  output logic ready
);
  logic [3:0] held_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held_q <= 4'h0;
    end else begin
      held_q <= ext_strobe ? held_q + 4'h1 : 4'h0;
    end
  end
  // Ready stays high between accesses, so a stall is only seen inside one
  assign ready = !(ext_strobe && held_q < stall);
endmodule
`default_nettype wire

// *** test/external_bus_wait_bank_control_test.sv ***
// Testbench for the external bus wait and bank control
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module external_bus_wait_bank_control_test;
  import ebw_pkg::*;
  logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, mmr_wr = 1'b0, mmr_rd = 1'b0, acc_req = 1'b0, acc_write = 1'b0;
  logic [15:0] mmr_addr = 16'h0000, mmr_wdata = 16'h0000, acc_addr = 16'h0000, acc_wdata = 16'h0000;
  logic [1:0] acc_space = 2'h0;
  logic [3:0] stall = 4'h0;
  logic [15:0] mmr_rdata, ext_addr, ext_dout;
  logic ready, acc_done, ext_dout_en_n, ext_strobe, ext_rw, io_space_strobe;
  logic ext_bus_keeper, host_bus_keeper, mode_bits_locked;
  int mismatches = 0, n_checks = 0;
  ebw_bus_ctrl dut_u (.clk(clk), .rst(rst), .clk_en(clk_en), .mmr_wr(mmr_wr), .mmr_rd(mmr_rd),
    .mmr_addr(mmr_addr), .mmr_wdata(mmr_wdata), .mmr_rdata(mmr_rdata), .acc_req(acc_req),
    .acc_write(acc_write), .acc_space(acc_space), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .ready(ready), .acc_done(acc_done), .ext_addr(ext_addr), .ext_dout(ext_dout),
    .ext_dout_en_n(ext_dout_en_n), .ext_strobe(ext_strobe), .ext_rw(ext_rw),
    .io_space_strobe(io_space_strobe), .ext_bus_keeper(ext_bus_keeper),
    .host_bus_keeper(host_bus_keeper), .mode_bits_locked(mode_bits_locked));
  ebw_ext_mem mem_u (.clk(clk), .rst(rst), .ext_strobe(ext_strobe), .stall(stall), .ready(ready));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    mmr_wr = 1'b1;
    mmr_addr = a;
    mmr_wdata = d;
    @(negedge clk);
    mmr_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(negedge clk);
    mmr_rd = 1'b1;
    mmr_addr = a;
    @(negedge clk);
    mmr_rd = 1'b0;
    @(negedge clk);
    `CHK("rdata", e, mmr_rdata)
  endtask
  // Latency counted in clock edges from the taking edge to the done pulse, both edges included
  task automatic acc(input logic w, input logic [1:0] sp, input logic [15:0] a, input int lat);
    int n;
    logic io_s, rw_s, en_s;
    logic [15:0] ad_s, do_s;
    n = 0;
    @(negedge clk);
    acc_req = 1'b1;
    acc_write = w;
    acc_space = sp;
    acc_addr = a;
    acc_wdata = ~a;
    while (acc_done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
      if (ext_strobe === 1'b1) begin
        io_s = io_space_strobe;
        rw_s = ext_rw;
        en_s = ext_dout_en_n;
        ad_s = ext_addr;
        do_s = ext_dout;
      end
    end
    acc_req = 1'b0;
    `CHK("latency", lat, n)
    `CHK("io strobe", sp == 2'h2, io_s)
    `CHK("rw", !w, rw_s)
    `CHK("addr", a, ad_s)
    if (w) begin
      `CHK("dout en", 1'b0, en_s)
      `CHK("dout", ~a, do_s)
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd(EBW_WAIT_STATE_BASE_ADDR, 16'h7FFF);
    rd(EBW_BANK_SWITCH_CONTROL_ADDR, 16'hF800);
    rd(EBW_WAIT_STATE_CONTROL_ADDR, 16'h0000);
    rd(16'h0030, 16'h0000);
    acc(1'b0, EBW_SPACE_PROG, 16'h0000, 9);
    wr(EBW_WAIT_STATE_CONTROL_ADDR, 16'hFFFF);
    rd(EBW_WAIT_STATE_CONTROL_ADDR, 16'h0001);
    acc(1'b0, EBW_SPACE_PROG, 16'h0000, 16);
    wr(EBW_WAIT_STATE_CONTROL_ADDR, 16'h0000);
    // Enable low must freeze the registers
    clk_en = 1'b0;
    wr(EBW_WAIT_STATE_CONTROL_ADDR, 16'h0001);
    clk_en = 1'b1;
    rd(EBW_WAIT_STATE_CONTROL_ADDR, 16'h0000);
    wr(EBW_BANK_SWITCH_CONTROL_ADDR, 16'hFFFE);
    rd(EBW_BANK_SWITCH_CONTROL_ADDR, 16'hF806);
    `CHK("ext keeper", 1'b1, ext_bus_keeper)
    `CHK("host keeper", 1'b1, host_bus_keeper)
    wr(EBW_BANK_SWITCH_CONTROL_ADDR, 16'hF800);
    @(negedge clk);
    `CHK("keepers off", 2'h0, {ext_bus_keeper, host_bus_keeper})
    wr(EBW_WAIT_STATE_BASE_ADDR, 16'h0000);
    acc(1'b0, EBW_SPACE_PROG, 16'h0000, 2);
    acc(1'b0, EBW_SPACE_PROG, 16'h1000, 3);
    acc(1'b0, EBW_SPACE_DATA, 16'h1000, 3);
    acc(1'b0, EBW_SPACE_DATA, 16'h1000, 2);
    acc(1'b0, EBW_SPACE_PROG, 16'h1000, 3);
    wr(EBW_BANK_SWITCH_CONTROL_ADDR, 16'hF000);
    acc(1'b0, EBW_SPACE_PROG, 16'h1000, 2);
    acc(1'b0, EBW_SPACE_DATA, 16'h1000, 2);
    acc(1'b0, EBW_SPACE_PROG, 16'h1000, 3);
    acc(1'b1, EBW_SPACE_PROG, 16'h2000, 3);
    wr(EBW_BANK_SWITCH_CONTROL_ADDR, 16'h0000);
    acc(1'b0, EBW_SPACE_PROG, 16'h5000, 2);
    acc(1'b0, EBW_SPACE_IO, 16'hFFFF, 2);
    acc(1'b1, EBW_SPACE_IO, 16'h0001, 2);
    stall = 4'h3;
    acc(1'b0, EBW_SPACE_PROG, 16'h5000, 5);
    stall = 4'h0;
    wr(EBW_BANK_SWITCH_CONTROL_ADDR, 16'h0001);
    // Taken on the edge the off bit is seen, so it must still finish
    acc_req = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("finish before off", 1'b1, acc_done)
    @(negedge clk);
    `CHK("locked", 1'b1, mode_bits_locked)
    repeat (10) begin
      @(negedge clk);
      `CHK("refused", 18'h00000, {acc_done, ext_strobe, ext_addr})
    end
    acc_req = 1'b0;
    wr(EBW_BANK_SWITCH_CONTROL_ADDR, 16'h0000);
    acc(1'b0, EBW_SPACE_PROG, 16'h5000, 2);
    `CHK("unlocked", 1'b0, mode_bits_locked)
    tally_and_finish;
  end
endmodule
`default_nettype wire
